// *** src/epaper_cmd_map.vh ***
// command codes, field defaults and table lengths of the e-paper command decoder
// Overview of operation
// [RULE_01] data phase is host write or device read
// [RULE_02] latch only valid bits of each parameter
// [RULE_03] after 10h store pixel bytes until next command
// [RULE_04] 20h common table, 44 parameter bytes
// [RULE_05] 21h white-white table, 42 parameter bytes
// [RULE_06] 22h bytes go to black-white table
// [RULE_07] 23h bytes go to white-black table
// [RULE_08] 24h bytes go to black-black table
// [RULE_09] 42h three bytes forwarded to sensor
// [RULE_10] 43h returns sensor high then low
// [RULE_11] select low is command, high is data
// [RULE_12] host waits while busy output is low
// [RULE_13] transfers accepted only with chip select low
// [RULE_14] framing select low 8-bit, high 9-bit
// [RULE_15] count parameters, ignore bytes beyond list
// [RULE_16] reset restores defaults, awaits new command
`ifndef EPAPER_CMD_MAP_VH
`define EPAPER_CMD_MAP_VH
// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define CMD_PANEL_SETUP     8'h00
`define CMD_SUPPLY_SETUP    8'h01
`define CMD_SUPPLY_OFF      8'h02
`define CMD_OFF_SEQUENCE    8'h03
`define CMD_SUPPLY_ON       8'h04
`define CMD_BOOSTER         8'h06
`define CMD_DEEP_SLEEP      8'h07
`define CMD_MONO_PIXEL      8'h10
`define CMD_DATA_STOP       8'h11
`define CMD_REDRAW          8'h12
`define CMD_RED_PIXEL       8'h13
`define CMD_COMMON_TABLE    8'h20
`define CMD_BB_TABLE        8'h24
`define CMD_OSC_CTRL        8'h30
`define CMD_SENSOR_CAL      8'h40
`define CMD_SENSOR_SEL      8'h41
`define CMD_SENSOR_WRITE    8'h42
`define CMD_SENSOR_READ     8'h43
`define CMD_NONE            8'hFF
`define SLEEP_CHECK         8'hA5
// ----------------------------------------------------------------
// table lengths (parameter bytes, command byte excluded)
// ----------------------------------------------------------------
`define COMMON_TABLE_LEN    6'h2C
`define PIXEL_TABLE_LEN     6'h2A
`define IDX_MAX             6'h3F
// ----------------------------------------------------------------
// framing and field defaults
// ----------------------------------------------------------------
`define LAST_BIT_4WIRE      4'h7
`define LAST_BIT_3WIRE      4'h8
`define DEF_PANEL           8'h0F
`define DEF_SUPPLY_CTRL     2'h3
`define DEF_SUPPLY_LEVEL    3'h0
`define DEF_VDH             6'h26
`define DEF_VDL             6'h26
`define DEF_VDHR            6'h03
`define DEF_OFF_SEQ         2'h0
`define DEF_BOOST_AB        8'h17
`define DEF_BOOST_C         6'h17
`define DEF_OSC             6'h3C
`define DEF_SENSOR_SEL      5'h00
`endif

// *** src/epaper_command_decoder.v ***
// serial command decoder of the e-paper driver with its pixel FIFO
`timescale 1ns/1ns
`include "epaper_cmd_map.vh"

// ----------------------------------------------------------------
// pixel FIFO
// ----------------------------------------------------------------
module pixel_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk,
	input  wire             rst,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_reg;
	reg [AW-1:0]    rd_reg;
	reg [AW:0]      count_reg;
	wire push = in_valid & in_ready;
	wire pop  = out_valid & out_ready;
	assign in_ready  = (count_reg != DEPTH[AW:0]);
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data  = mem[rd_reg];
	always @(posedge clk) begin
		if (push)
			mem[wr_reg] <= in_data;
	end
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_reg    <= {AW{1'b0}};
			rd_reg    <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
			if (pop)
				rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
			if (push & ~pop)
				count_reg <= count_reg + 1'b1;
			else if (pop & ~push)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule // pixel_fifo

// ----------------------------------------------------------------
// command decoder
// ----------------------------------------------------------------
module epaper_command_decoder #(
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW    = 4
) (
	input  wire       clk,
	input  wire       rst,
	input  wire       res_n,
	input  wire       cs_n,
	input  wire       dc,
	input  wire       sclk,
	input  wire       sdin,
	output wire       sdout,
	output wire       sdout_oe,
	input  wire       bus_framing_select,
	output wire       busy_n,
	input  wire       wave_busy,
	output wire       pix_valid,
	input  wire       pix_ready,
	output wire [7:0] pix_data,
	output wire       pix_red,
	output reg        lut_we,
	output reg  [2:0] lut_sel,
	output reg  [5:0] lut_addr,
	output reg  [7:0] lut_data,
	output reg        sensor_wr_req,
	output reg  [7:0] sensor_attr_byte,
	output reg  [7:0] sensor_wr_high,
	output reg  [7:0] sensor_wr_low,
	output reg        sensor_rd_req,
	input  wire [7:0] sensor_rd_high,
	input  wire [7:0] sensor_rd_low,
	input  wire       sensor_busy,
	output reg  [7:0] panel_setting,
	output reg  [1:0] supply_ctrl,
	output reg  [2:0] supply_level,
	output reg  [5:0] supply_vdh,
	output reg  [5:0] supply_vdl,
	output reg  [5:0] supply_vdhr,
	output reg  [1:0] off_sequence,
	output reg  [7:0] boost_phase_a,
	output reg  [7:0] boost_phase_b,
	output reg  [5:0] boost_phase_c,
	output reg  [5:0] osc_setting,
	output reg  [4:0] sensor_select,
	output reg        supply_on,
	output reg        deep_sleep,
	output reg        redraw_pulse
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	reg [2:0] sclk_s;
	reg [1:0] din_s;
	reg [1:0] cs_s;
	reg [1:0] dc_s;
	reg [1:0] bs_s;
	reg [1:0] res_s;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sclk_s <= 3'h0;
			din_s  <= 2'h0;
			cs_s   <= 2'h3;
			dc_s   <= 2'h0;
			bs_s   <= 2'h0;
			res_s  <= 2'h3;
		end else begin
			sclk_s <= {sclk_s[1:0], sclk};
			din_s  <= {din_s[0], sdin};
			cs_s   <= {cs_s[0], cs_n};
			dc_s   <= {dc_s[0], dc};
			bs_s   <= {bs_s[0], bus_framing_select};
			res_s  <= {res_s[0], res_n};
		end
	end
	wire       rise   = sclk_s[1] & ~sclk_s[2];
	wire       fall   = ~sclk_s[1] & sclk_s[2];
	wire       active = ~cs_s[1]; // RULE_13
	wire       three  = bs_s[1];
	wire [3:0] last   = three ? `LAST_BIT_3WIRE : `LAST_BIT_4WIRE; // RULE_14

	// ----------------------------------------------------------------
	// serial receive and transmit
	// ----------------------------------------------------------------
	reg  [3:0] bit_cnt;
	reg  [6:0] shift;
	reg        dc_bit;
	reg  [7:0] tx;
	reg  [7:0] cmd_reg;
	reg  [5:0] idx;
	reg        data_flag;
	reg  [7:0] rd_byte;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			bit_cnt <= 4'h0;
			shift   <= 7'h00;
			dc_bit  <= 1'b0;
		end else if (!active || !res_s[1]) begin
			bit_cnt <= 4'h0; // RULE_16
		end else if (rise) begin
			if (three && bit_cnt == 4'h0)
				dc_bit <= din_s[1]; // RULE_14
			else
				shift <= {shift[5:0], din_s[1]};
			bit_cnt <= (bit_cnt == last) ? 4'h0 : bit_cnt + 4'h1;
		end
	end
	wire       byte_done = active & rise & (bit_cnt == last) & ~deep_sleep;
	wire [7:0] rx        = {shift, din_s[1]};
	wire       is_data   = three ? dc_bit : dc_s[1]; // RULE_11
	wire       rd_cmd    = (cmd_reg == `CMD_SENSOR_READ) | (cmd_reg == `CMD_DATA_STOP) |
		(cmd_reg == `CMD_SENSOR_CAL);
	wire       rd_phase  = rd_cmd & (three ? (bit_cnt != 4'h0) & dc_bit : dc_s[1]); // RULE_01

	always @* begin
		case (cmd_reg)
			`CMD_SENSOR_READ: rd_byte = (idx == 6'h00) ? sensor_rd_high : sensor_rd_low; // RULE_10
			`CMD_SENSOR_CAL:  rd_byte = (idx == 6'h00) ? sensor_rd_high : {sensor_rd_low[7:5], 5'h00};
			`CMD_DATA_STOP:   rd_byte = {data_flag, 7'h00};
			default:          rd_byte = 8'h00;
		endcase
	end
	always @(posedge clk or posedge rst) begin
		if (rst)
			tx <= 8'h00;
		else if (bit_cnt == 4'h0 && !rise)
			tx <= rd_byte;
		else if (fall && bit_cnt != 4'h0 && !(three && bit_cnt == 4'h1))
			tx <= {tx[6:0], 1'b0};
	end
	assign sdout    = tx[7];
	assign sdout_oe = active & rd_phase & ~deep_sleep; // RULE_01

	// ----------------------------------------------------------------
	// pixel path
	// ----------------------------------------------------------------
	wire fifo_in_ready;
	wire pix_cmd   = (cmd_reg == `CMD_MONO_PIXEL) | (cmd_reg == `CMD_RED_PIXEL);
	wire pix_push  = byte_done & is_data & pix_cmd; // RULE_03
	wire [8:0] fifo_out;
	pixel_fifo #(
		.WIDTH (9),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (pix_push),
		.in_ready  (fifo_in_ready),
		.in_data   ({cmd_reg[0], rx}),
		.out_valid (pix_valid),
		.out_ready (pix_ready),
		.out_data  (fifo_out)
	);
	assign pix_red  = fifo_out[8];
	assign pix_data = fifo_out[7:0];
	// host must hold off while this is low
	assign busy_n = ~(wave_busy | sensor_busy | ~fifo_in_ready); // RULE_12

	// ----------------------------------------------------------------
	// command and parameter decode
	// ----------------------------------------------------------------
	task set_defaults;
		begin
			cmd_reg          <= `CMD_NONE;
			idx              <= 6'h00;
			data_flag        <= 1'b0;
			panel_setting    <= `DEF_PANEL;
			supply_ctrl      <= `DEF_SUPPLY_CTRL;
			supply_level     <= `DEF_SUPPLY_LEVEL;
			supply_vdh       <= `DEF_VDH;
			supply_vdl       <= `DEF_VDL;
			supply_vdhr      <= `DEF_VDHR;
			off_sequence     <= `DEF_OFF_SEQ;
			boost_phase_a    <= `DEF_BOOST_AB;
			boost_phase_b    <= `DEF_BOOST_AB;
			boost_phase_c    <= `DEF_BOOST_C;
			osc_setting      <= `DEF_OSC;
			sensor_select    <= `DEF_SENSOR_SEL;
			sensor_attr_byte <= 8'h00;
			sensor_wr_high   <= 8'h00;
			sensor_wr_low    <= 8'h00;
			supply_on        <= 1'b0;
			deep_sleep       <= 1'b0;
		end
	endtask
	wire lut_cmd = (cmd_reg >= `CMD_COMMON_TABLE) & (cmd_reg <= `CMD_BB_TABLE);
	wire [5:0] lut_len = (cmd_reg == `CMD_COMMON_TABLE) ? `COMMON_TABLE_LEN : `PIXEL_TABLE_LEN;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			set_defaults; // RULE_16
			lut_we        <= 1'b0;
			lut_sel       <= 3'h0;
			lut_addr      <= 6'h00;
			lut_data      <= 8'h00;
			sensor_wr_req <= 1'b0;
			sensor_rd_req <= 1'b0;
			redraw_pulse  <= 1'b0;
		end else begin
			lut_we        <= 1'b0;
			sensor_wr_req <= 1'b0;
			sensor_rd_req <= 1'b0;
			redraw_pulse  <= 1'b0;
			if (!res_s[1]) begin
				set_defaults; // RULE_16
			end else if (byte_done && !is_data) begin
				cmd_reg <= rx; // RULE_11
				idx     <= 6'h00;
				case (rx)
					`CMD_SUPPLY_OFF:  supply_on <= 1'b0;
					`CMD_SUPPLY_ON:   supply_on <= 1'b1;
					`CMD_REDRAW:      redraw_pulse <= 1'b1;
					`CMD_SENSOR_READ: sensor_rd_req <= 1'b1;
					`CMD_SENSOR_CAL:  sensor_rd_req <= 1'b1;
					default:          ;
				endcase
			end else if (byte_done) begin
				if (idx != `IDX_MAX)
					idx <= idx + 6'h01; // RULE_15
				if (pix_push)
					data_flag <= 1'b1;
				else if (cmd_reg == `CMD_DATA_STOP)
					data_flag <= 1'b0;
				if (lut_cmd && idx < lut_len) begin
					lut_we   <= 1'b1; // RULE_04 RULE_05 RULE_06 RULE_07 RULE_08
					lut_sel  <= cmd_reg[2:0];
					lut_addr <= idx;
					lut_data <= rx;
				end
				case (cmd_reg)
					`CMD_PANEL_SETUP:
						if (idx == 6'h00)
							panel_setting <= rx;
					`CMD_SUPPLY_SETUP:
						case (idx) // RULE_02
							6'h00:   supply_ctrl  <= rx[1:0];
							6'h01:   supply_level <= rx[2:0];
							6'h02:   supply_vdh   <= rx[5:0];
							6'h03:   supply_vdl   <= rx[5:0];
							6'h04:   supply_vdhr  <= rx[5:0];
							default: ;
						endcase
					`CMD_OFF_SEQUENCE:
						if (idx == 6'h00)
							off_sequence <= rx[5:4]; // RULE_02
					`CMD_BOOSTER:
						case (idx)
							6'h00:   boost_phase_a <= rx;
							6'h01:   boost_phase_b <= rx;
							6'h02:   boost_phase_c <= rx[5:0]; // RULE_02
							default: ;
						endcase
					`CMD_DEEP_SLEEP:
						if (idx == 6'h00 && rx == `SLEEP_CHECK)
							deep_sleep <= 1'b1;
					`CMD_OSC_CTRL:
						if (idx == 6'h00)
							osc_setting <= rx[5:0];
					`CMD_SENSOR_SEL:
						if (idx == 6'h00)
							sensor_select <= {rx[7], rx[3:0]}; // RULE_02
					`CMD_SENSOR_WRITE:
						case (idx) // RULE_09
							6'h00:   sensor_attr_byte <= rx;
							6'h01:   sensor_wr_high <= rx;
							6'h02: begin
								sensor_wr_low <= rx;
								sensor_wr_req <= 1'b1;
							end
							default: ;
						endcase
					default: ;
				endcase
			end
		end
	end
endmodule // epaper_command_decoder

// *** testbench/decoder_asserts.sv ***
// concurrent checks on the ports of the e-paper command decoder
`timescale 1ns/1ns
module decoder_asserts (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       res_n,
	input wire logic       cs_n,
	input wire logic       wave_busy,
	input wire logic       sensor_busy,
	input wire logic       pix_ready,
	input wire logic       busy_n,
	input wire logic       sdout_oe,
	input wire logic       pix_valid,
	input wire logic [7:0] pix_data,
	input wire logic       lut_we,
	input wire logic [2:0] lut_sel,
	input wire logic [5:0] lut_addr,
	input wire logic       sensor_wr_req,
	input wire logic [7:0] panel_setting,
	input wire logic       deep_sleep
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ----------------------------------------------------------------
	// sequences
	// ----------------------------------------------------------------
	sequence s_res_low; !res_n [*6]; endsequence
	sequence s_cs_idle; cs_n [*4]; endsequence
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	AST_LUT_SEL: assert property (lut_we |-> lut_sel <= 3'h4)
		else $error("table select out of range");
	AST_LUT_LEN: assert property (lut_we |-> lut_addr < 6'h2C)
		else $error("common table index beyond its list");
	AST_PIX_LEN: assert property (lut_we && lut_sel != 3'h0 |-> lut_addr < 6'h2A)
		else $error("pixel table index beyond its list");
	AST_LUT_GAP: assert property (lut_we |=> !lut_we [*4])
		else $error("table write longer than one cycle");
	AST_CS_OE: assert property (s_cs_idle |-> !sdout_oe)
		else $error("data pin driven while deselected");
	AST_WAVE_BUSY: assert property (wave_busy |-> !busy_n)
		else $error("busy not shown during waveform drive");
	AST_SNS_BUSY: assert property (sensor_busy |-> !busy_n)
		else $error("busy not shown during sensor access");
	AST_RES_DEF: assert property (s_res_low |-> panel_setting == 8'h0F && !deep_sleep)
		else $error("settings not restored by reset pin");
	AST_PIX_HOLD: assert property (pix_valid && !pix_ready && res_n |=> pix_valid && $stable(pix_data))
		else $error("pixel stream dropped while stalled");
	AST_WR_PULSE: assert property (sensor_wr_req |=> !sensor_wr_req)
		else $error("sensor write request not a pulse");
endmodule // decoder_asserts

bind epaper_command_decoder decoder_asserts chk_u (.clk, .rst, .res_n, .cs_n, .wave_busy,
	.sensor_busy, .pix_ready, .busy_n, .sdout_oe, .pix_valid, .pix_data, .lut_we, .lut_sel,
	.lut_addr, .sensor_wr_req, .panel_setting, .deep_sleep);

// *** testbench/host_link_model.sv ***
// host side of the serial link: select, data/command, clock and data pins
`timescale 1ns/1ns
module host_link_model (
	output logic cs_n,
	output logic dc,
	output logic sclk,
	output logic sdin,
	input  wire  sdout
);
	initial begin
		cs_n = 1'b1;
		dc = 1'b0;
		sclk = 1'b0;
		sdin = 1'b0;
	end
	// one bit: data set up, read data taken at the rising edge
	task automatic bit_out(input logic d, output logic s);
		sdin = d;
		#62 sclk = 1'b1;
		s = sdout;
		#63 sclk = 1'b0;
	endtask
	// one byte msb first; w9 sends the data/command flag first; sel low keeps the device deselected
	task automatic xfer(input logic c, input logic [7:0] b, input logic w9, input logic sel,
		output logic [7:0] q);
		logic s;
		cs_n = ~sel;
		dc = c;
		if (w9) bit_out(c, s);
		for (int i = 7; i >= 0; i--) begin
			bit_out(b[i], s);
			q[i] = s;
		end
		#100 cs_n = 1'b1;
		sdin = ~sdin;
		// deselect gap so back-to-back frames never share a time step
		#100;
	endtask
endmodule // host_link_model

// *** testbench/testbench.sv ***
// self-checking bench of the e-paper command decoder
`timescale 1ns/1ns
module testbench;
	logic clk = 0, rst = 1, res_n = 1, bus_framing_select = 0, wave_busy = 0, sensor_busy = 0;
	logic pix_ready = 1, last_red;
	logic [5:0] last_addr;
	logic [7:0] sensor_rd_high = 8'h9C, sensor_rd_low = 8'h3A, q, last_data;
	logic [7:0] pix_q[$];
	int mismatches = 0, cmp_count = 0, we_n = 0, wr_n = 0, rd_n = 0, rf_n = 0, oe_n = 0;
	wire cs_n, dc, sclk, sdin, sdout, sdout_oe, busy_n, pix_valid, pix_red, lut_we, sensor_wr_req;
	wire sensor_rd_req, supply_on, deep_sleep, redraw_pulse;
	wire [7:0] pix_data, lut_data, sensor_attr_byte, sensor_wr_high, sensor_wr_low, panel_setting;
	wire [7:0] boost_phase_a, boost_phase_b;
	wire [5:0] lut_addr, supply_vdh, supply_vdl, supply_vdhr, boost_phase_c, osc_setting;
	wire [4:0] sensor_select;
	wire [2:0] lut_sel, supply_level;
	wire [1:0] supply_ctrl, off_sequence;
	always #4 clk = ~clk;
	host_link_model host_u (.cs_n, .dc, .sclk, .sdin, .sdout);
	epaper_command_decoder dut_u (.clk, .rst, .res_n, .cs_n, .dc, .sclk, .sdin, .sdout, .sdout_oe,
		.bus_framing_select, .busy_n, .wave_busy, .pix_valid, .pix_ready, .pix_data, .pix_red,
		.lut_we, .lut_sel, .lut_addr, .lut_data, .sensor_wr_req, .sensor_attr_byte,
		.sensor_wr_high, .sensor_wr_low, .sensor_rd_req, .sensor_rd_high, .sensor_rd_low,
		.sensor_busy, .panel_setting, .supply_ctrl, .supply_level, .supply_vdh, .supply_vdl,
		.supply_vdhr, .off_sequence, .boost_phase_a, .boost_phase_b, .boost_phase_c, .osc_setting,
		.sensor_select, .supply_on, .deep_sleep, .redraw_pulse);
	// ----------------------------------------------------------------
	// monitors and helpers
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (lut_we) begin
			we_n++;
			last_data <= lut_data;
			last_addr <= lut_addr;
		end
		if (pix_valid && pix_ready) begin
			pix_q.push_back(pix_data);
			last_red <= pix_red;
		end
		if (sensor_wr_req) wr_n++;
		if (sensor_rd_req) rd_n++;
		if (redraw_pulse) rf_n++;
		if (sdout_oe) oe_n++;
	end
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic c, input logic [7:0] b);
		while (!c && !busy_n) @(posedge clk) #1;
		host_u.xfer(c, b, bus_framing_select, 1'b1, q);
		#200;
	endtask
	task automatic rd;
		host_u.xfer(1, 8'h00, bus_framing_select, 1'b1, q);
		#200;
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_defaults;
		chk("panel", panel_setting, 8'h0F);
		chk("ctrl", supply_ctrl, 8'h03);
		chk("vdh", supply_vdh, 8'h26);
		chk("vdhr", supply_vdhr, 8'h03);
		chk("osc", osc_setting, 8'h3C);
		chk("busy", busy_n, 8'h01);
	endtask
	task automatic t_settings;
		wr(0, 8'h00); wr(1, 8'h5B); wr(1, 8'h77);
		chk("panel", panel_setting, 8'h5B);
		wr(0, 8'h01); wr(1, 8'hFE); wr(1, 8'hFD); wr(1, 8'hC1); wr(1, 8'hC2); wr(1, 8'hC4);
		wr(1, 8'h00);
		chk("ctrl", supply_ctrl, 8'h02);
		chk("level", supply_level, 8'h05);
		chk("vdh", supply_vdh, 8'h01);
		chk("vdl", supply_vdl, 8'h02);
		chk("vdhr", supply_vdhr, 8'h04);
		wr(0, 8'h03); wr(1, 8'hFF);
		chk("offseq", off_sequence, 8'h03);
		wr(0, 8'h41); wr(1, 8'hFF);
		chk("sel", sensor_select, 8'h1F);
		wr(0, 8'h06); wr(1, 8'h11); wr(1, 8'h22); wr(1, 8'hFF);
		chk("boost", {boost_phase_a[3:0], boost_phase_b[3:0]}, 8'h12);
		chk("boostc", boost_phase_c, 8'h3F);
		wr(0, 8'h04);
		chk("on", supply_on, 8'h01);
		wr(0, 8'h12);
		chk("redraw", rf_n[7:0], 8'h01);
		wr(0, 8'h02);
		chk("off", supply_on, 8'h00);
	endtask
	task automatic t_tables;
		for (int k = 0; k < 5; k++) begin
			we_n = 0;
			wr(0, 8'h20 + k[7:0]);
			for (int i = 0; i <= (k == 0 ? 44 : 42); i++) wr(1, i[7:0] ^ 8'h5A);
			chk("count", we_n[7:0], k == 0 ? 8'd44 : 8'd42);
			chk("tsel", lut_sel, k[7:0]);
			chk("tdata", last_data, (k == 0 ? 8'd43 : 8'd41) ^ 8'h5A);
			chk("taddr", last_addr, k == 0 ? 8'd43 : 8'd41);
		end
	endtask
	task automatic t_pixels;
		@(posedge clk) #1 pix_ready = 0;
		wr(0, 8'h10);
		for (int i = 0; i < 17; i++) wr(1, i[7:0]);
		chk("full", busy_n, 8'h00);
		@(posedge clk) #1 pix_ready = 1;
		#500 chk("npix", pix_q.size(), 8'd16);
		chk("pix", pix_q[15], 8'h0F);
		chk("red", last_red, 8'h00);
		wr(0, 8'h13); wr(1, 8'h77);
		chk("rpix", pix_q[16], 8'h77);
		chk("red", last_red, 8'h01);
	endtask
	task automatic t_sensor;
		wr(0, 8'h42); wr(1, 8'hA1); wr(1, 8'hB2); wr(1, 8'hC3);
		chk("wreq", wr_n[7:0], 8'h01);
		chk("attr", sensor_attr_byte, 8'hA1);
		chk("whi", sensor_wr_high, 8'hB2);
		chk("wlo", sensor_wr_low, 8'hC3);
		wr(0, 8'h43);
		chk("rreq", rd_n[7:0], 8'h01);
		chk("oe0", oe_n[7:0], 8'h00);
		rd();
		chk("rhi", q, 8'h9C);
		rd();
		chk("rlo", q, 8'h3A);
		chk("oe", oe_n > 0, 8'h01);
		wr(0, 8'h11);
		rd();
		chk("dflag", q, 8'h80);
		rd();
		chk("dclr", q, 8'h00);
		wr(0, 8'h40);
		chk("creq", rd_n[7:0], 8'h02);
		rd();
		chk("chi", q, 8'h9C);
		rd();
		chk("clo", q, 8'h20);
		@(posedge clk) #1 wave_busy = 1;
		#20 chk("wbusy", busy_n, 8'h00);
		wave_busy = 0;
		sensor_busy = 1;
		#20 chk("sbusy", busy_n, 8'h00);
		sensor_busy = 0;
	endtask
	task automatic t_framing;
		bus_framing_select = 1;
		wr(0, 8'h30); wr(1, 8'h2A);
		chk("osc3w", osc_setting, 8'h2A);
		bus_framing_select = 0;
		host_u.xfer(0, 8'h30, 0, 0, q);
		host_u.xfer(1, 8'h11, 0, 0, q);
		chk("oscdes", osc_setting, 8'h2A);
	endtask
	task automatic t_sleep;
		wr(0, 8'h07); wr(1, 8'hA5);
		chk("sleep", deep_sleep, 8'h01);
		wr(0, 8'h30); wr(1, 8'h15);
		chk("slpign", osc_setting, 8'h2A);
		@(posedge clk) #1 res_n = 0;
		repeat (10) @(posedge clk);
		#1 res_n = 1;
		chk("sleep", deep_sleep, 8'h00);
		chk("osc", osc_setting, 8'h3C);
		chk("on", supply_on, 8'h00);
		chk("panel", panel_setting, 8'h0F);
		repeat (5) @(posedge clk);
	endtask
	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		#1 rst = 0;
		repeat (5) @(posedge clk);
		t_defaults(); t_settings(); t_tables(); t_pixels(); t_sensor(); t_framing(); t_sleep();
		end_sim();
	end
	initial begin
		#600000 mismatches++;
		end_sim();
	end
endmodule // testbench
